// file: can_wake_pkg.sv
// Shared constants, types and bus carriers of the CAN wake flag block
package can_wake_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned PHASE_NS = 5000;
  localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WINDOW_NS = 500000;
  localparam int unsigned WINDOW_CYC = WINDOW_NS / CLK_NS;
  localparam int unsigned WAKE_FILT_NS = 50000;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GTS_HOLD_NS = 50000;
  localparam int unsigned GTS_HOLD_CYC = (GTS_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
  // Fields
  localparam int CTRL_BUS_EN = 0;
  localparam int CTRL_LOC_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int ST_WAKE = 5;
  localparam int ST_BIAS = 6;
  localparam int ST_INH = 7;
  localparam int IRQ_BUS = 0;
  localparam int IRQ_LOC = 1;
  localparam int IRQ_SLEEP = 2;
  localparam int IRQ_FLAG = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchroniser lanes and their reset levels
  localparam int SY_DOM = 0;
  localparam int SY_WAKE = 1;
  localparam int SY_STANDBY_SELECT_N = 2;
  localparam int SY_EN = 3;
  localparam int SY_PON = 4;
  localparam int SY_UV = 5;
  localparam logic [5:0] SYNC_RST = 6'h02;
  typedef enum logic [4:0] {
    M_NORMAL = 5'h01, M_LISTEN = 5'h02, M_GTS = 5'h04, M_STANDBY = 5'h08, M_SLEEP = 5'h10
  } mode_t;
  typedef enum logic [3:0] {
    BW_IDLE = 4'h1, BW_DOM1 = 4'h2, BW_REC = 4'h4, BW_DOM2 = 4'h8
  } bwake_t;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic [2:0] awprot;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb; logic bready;
    logic arvalid; logic [31:0] araddr; logic [2:0] arprot; logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axil_rsp_t;
endpackage : can_wake_pkg

// file: can_wake_flag.sv
// Wake detection, wake flag signalling and mode control of a CAN transceiver
// What this block does
// - Bus wake needs dominant, recessive, dominant phases of 5 us within 0.5 ms.
// - Local wake fires on either edge of the wake pin after the filter time.
// - Wake pin bias follows the filtered pin level, high to battery, low to ground.
// - Inhibit output floats in Sleep while the wake flag is clear and is driven high otherwise.
// - Bus or local wake sets the flag only in Sleep, Standby or Go-to-Sleep.
// - In Normal and Listen-only modes wake events reach the interrupt status but not the wake flag.
// - In low-power modes fault status shows the wake flag, low means pending.
// - Receive data mirrors the wake flag with the same polarity while signalled.
// - Wake flag clears on entering Normal and on undervoltage flag set.
// - Sleep is never entered while the wake flag is set.
// - Wake flag is set together with the power-on flag.
// - Fault status output multiplexes flags by mode: wake flag in low-power modes, other flag otherwise.
// - Go-to-Sleep is standby select low, enable high; transmitter off, flag shown.
// - Go-to-Sleep held past the hold time enters Sleep and floats inhibit.
// - Rising standby select leaves Sleep for Normal or Listen-only by enable.
// - A wake coinciding with Go-to-Sleep wins and keeps inhibit driven.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module can_wake_flag #(
  parameter int unsigned WINDOW_CYC = can_wake_pkg::WINDOW_CYC,
  parameter int unsigned WAKE_FILT_CYC = can_wake_pkg::WAKE_FILT_CYC,
  parameter int unsigned GTS_HOLD_CYC = can_wake_pkg::GTS_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire can_wake_pkg::axil_req_t axi_req_i,
  output can_wake_pkg::axil_rsp_t axi_rsp_o,
  input wire logic bus_dominant_i,
  input wire logic wake_pin_i,
  input wire logic standby_select_n_i,
  input wire logic enable_i,
  input wire logic power_on_flag_i,
  input wire logic supply_undervoltage_flag_i,
  input wire logic other_flag_n_i,
  output logic fault_status_out_n_o,
  output logic rxd_o,
  output logic txd_enable_o,
  output logic regulator_inhibit_out_o,
  output logic regulator_inhibit_out_oe_o,
  output logic wake_bias_high_o,
  output logic irq_o
);
  import can_wake_pkg::*;

  function automatic mode_t pin_mode(input logic standby_select_n, input logic en);
    case ({standby_select_n, en})
      2'b11: pin_mode = M_NORMAL;
      2'b10: pin_mode = M_LISTEN;
      2'b01: pin_mode = M_GTS;
      default: pin_mode = M_STANDBY;
    endcase
  endfunction : pin_mode

  function automatic logic low_power(input mode_t m);
    low_power = (m == M_GTS) || (m == M_STANDBY) || (m == M_SLEEP);
  endfunction : low_power

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  // Pin synchronisers: a change counts once stages two and three agree
  logic [5:0] s1_q, s2_q, s3_q, filt_q, filt_d, fprev_q;
  logic standby_select_n_rise, pon_rise, uv_rise;
  always_comb begin
    filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      filt_q <= SYNC_RST;
      fprev_q <= SYNC_RST;
    end else begin
      s1_q <= {supply_undervoltage_flag_i, power_on_flag_i, enable_i, standby_select_n_i,
               wake_pin_i, bus_dominant_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      fprev_q <= filt_q;
    end
  end
  assign standby_select_n_rise = filt_q[SY_STANDBY_SELECT_N] & ~fprev_q[SY_STANDBY_SELECT_N];
  assign pon_rise = filt_q[SY_PON] & ~fprev_q[SY_PON];
  assign uv_rise = filt_q[SY_UV] & ~fprev_q[SY_UV];

  logic [1:0] ctrl_q, ctrl_d;
  logic wake_q, wake_d, wake_set;

  // Bus wake pattern detector, timed by the local clock
  bwake_t bw_q, bw_d;
  logic [9:0] ph_q, ph_d;
  logic [16:0] win_q, win_d;
  logic bus_wake, dom, ph_ok;
  always_comb begin
    dom = filt_q[SY_DOM] & ctrl_q[CTRL_BUS_EN];
    ph_ok = ph_q >= 10'(PHASE_CYC - 1);
    bw_d = bw_q;
    ph_d = (ph_q == 10'h3ff) ? ph_q : ph_q + 10'h001;
    win_d = (win_q == 17'h1ffff) ? win_q : win_q + 17'h00001;
    bus_wake = 1'b0;
    case (bw_q)
      BW_IDLE: begin
        ph_d = 10'h000;
        win_d = 17'h00000;
        if (dom) bw_d = BW_DOM1;
      end
      BW_DOM1: if (!dom) begin
        ph_d = 10'h000;
        bw_d = ph_ok ? BW_REC : BW_IDLE;
      end
      BW_REC: if (dom) begin
        ph_d = 10'h000;
        bw_d = ph_ok ? BW_DOM2 : BW_DOM1;
        if (!ph_ok) win_d = 17'h00000; // Short gap: this dominant starts afresh
      end
      BW_DOM2: begin
        if (!dom) begin
          bw_d = BW_IDLE;
        end else if (ph_ok) begin
          bus_wake = 1'b1;
          bw_d = BW_IDLE;
        end
      end
      default: bw_d = BW_IDLE;
    endcase
    if (bw_q != BW_IDLE && win_q >= 17'(WINDOW_CYC - 1)) begin
      bus_wake = 1'b0;
      bw_d = BW_IDLE;
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bw_q <= BW_IDLE;
      ph_q <= 10'h000;
      win_q <= 17'h00000;
    end else begin
      bw_q <= bw_d;
      ph_q <= ph_d;
      win_q <= win_d;
    end
  end

  // Local wake filter with adaptive bias; the bias moves even if wake is disabled
  logic bias_q, bias_d, loc_wake;
  logic [15:0] fc_q, fc_d;
  always_comb begin
    bias_d = bias_q;
    fc_d = 16'h0000;
    loc_wake = 1'b0;
    if (filt_q[SY_WAKE] != bias_q) begin
      if (fc_q >= 16'(WAKE_FILT_CYC - 1)) begin
        bias_d = filt_q[SY_WAKE];
        loc_wake = ctrl_q[CTRL_LOC_EN];
      end else begin
        fc_d = fc_q + 16'h0001;
      end
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bias_q <= 1'b1;
      fc_q <= 16'h0000;
    end else begin
      bias_q <= bias_d;
      fc_q <= fc_d;
    end
  end

  // Operating mode from the host pins
  mode_t state_q, state_d, req;
  logic [15:0] gts_q, gts_d;
  always_comb begin
    req = pin_mode(filt_q[SY_STANDBY_SELECT_N], filt_q[SY_EN]);
    state_d = state_q;
    gts_d = 16'h0000;
    case (state_q)
      M_SLEEP: if (standby_select_n_rise) state_d = filt_q[SY_EN] ? M_NORMAL : M_LISTEN;
      M_GTS: begin
        if (req != M_GTS) begin
          state_d = req;
        end else if (wake_q || wake_set) begin
          gts_d = gts_q;
        end else if (gts_q >= 16'(GTS_HOLD_CYC - 1)) begin
          state_d = M_SLEEP;
        end else begin
          gts_d = gts_q + 16'h0001;
        end
      end
      default: state_d = req;
    endcase
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= M_STANDBY;
      gts_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      gts_q <= gts_d;
    end
  end

  // Wake flag: a set in the same cycle as a clear wins
  always_comb begin
    // set only in low-power modes; power-on set
    wake_set = (low_power(state_q) && (bus_wake || loc_wake)) || pon_rise;
    // clear on Normal entry or undervoltage
    wake_d = wake_set || (wake_q && !((state_d == M_NORMAL && state_q != M_NORMAL) || uv_rise));
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) wake_q <= 1'b1; // Power-up counts as first battery connection
    else wake_q <= wake_d;
  end

  // Registered pin outputs
  logic fault_status_out_n_q, rxd_q, txen_q, inh_oe_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_status_out_n_q <= 1'b0;
      rxd_q <= 1'b0;
      txen_q <= 1'b0;
      inh_oe_q <= 1'b1;
    end else begin
      fault_status_out_n_q <= low_power(state_d) ? !wake_d : other_flag_n_i;
      rxd_q <= low_power(state_d) ? !wake_d : !filt_d[SY_DOM];
      txen_q <= (state_d == M_NORMAL);
      // inhibit float only in quiet Sleep
      inh_oe_q <= (state_d != M_SLEEP) || wake_d;
    end
  end
  assign fault_status_out_n_o = fault_status_out_n_q;
  assign rxd_o = rxd_q;
  assign txd_enable_o = txen_q;
  assign regulator_inhibit_out_o = 1'b1; // Only driven while the output enable inh_oe_q is high
  assign regulator_inhibit_out_oe_o = inh_oe_q;
  assign wake_bias_high_o = bias_q;

  // AXI4-Lite slave with sticky interrupt status; one write and one read in flight
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [31:0] awa_q, awa_d, wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d, stat_q, stat_d, mask_q, mask_d, ev;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic wr_go;
  always_comb begin
    ev = 4'h0;
    ev[IRQ_BUS] = bus_wake;
    ev[IRQ_LOC] = loc_wake;
    ev[IRQ_SLEEP] = (state_d == M_SLEEP) && (state_q != M_SLEEP);
    ev[IRQ_FLAG] = wake_d && !wake_q;
    aw_d = aw_q || (axi_req_i.awvalid && !aw_q && !bv_q);
    w_d = w_q || (axi_req_i.wvalid && !w_q && !bv_q);
    awa_d = (axi_req_i.awvalid && !aw_q && !bv_q) ? axi_req_i.awaddr : awa_q;
    wd_d = (axi_req_i.wvalid && !w_q && !bv_q) ? axi_req_i.wdata : wd_q;
    ws_d = (axi_req_i.wvalid && !w_q && !bv_q) ? axi_req_i.wstrb : ws_q;
    wr_go = aw_q && w_q && !bv_q;
    bv_d = wr_go || (bv_q && !axi_req_i.bready);
    br_d = br_q;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      br_d = addr_ok(awa_q) ? RESP_OK : RESP_SLVERR;
      if (addr_ok(awa_q) && ws_q[0]) begin
        case (awa_q[3:0])
          OFS_CTRL: ctrl_d = wd_q[1:0];
          OFS_IRQ_MASK: mask_d = wd_q[3:0];
          OFS_IRQ_STAT: stat_d = stat_q & ~wd_q[3:0];
          default: ;
        endcase
      end
    end
    stat_d = stat_d | ev; // An event in the clearing cycle is kept
    rv_d = rv_q ? !axi_req_i.rready : axi_req_i.arvalid;
    rd_d = rd_q;
    rr_d = rr_q;
    if (axi_req_i.arvalid && !rv_q) begin
      rd_d = 32'h0;
      rr_d = addr_ok(axi_req_i.araddr) ? RESP_OK : RESP_SLVERR;
      if (addr_ok(axi_req_i.araddr)) begin
        case (axi_req_i.araddr[3:0])
          OFS_STATUS: rd_d = {24'h0, inh_oe_q, bias_q, wake_q, state_q};
          OFS_CTRL: rd_d = {30'h0, ctrl_q};
          OFS_IRQ_STAT: rd_d = {28'h0, stat_q};
          default: rd_d = {28'h0, mask_q};
        endcase
      end
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 32'h0;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      ws_q <= 4'h0;
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      br_q <= RESP_OK;
      rr_q <= RESP_OK;
      ctrl_q <= CTRL_RST;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ws_q <= ws_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      br_q <= br_d;
      rr_q <= rr_d;
      ctrl_q <= ctrl_d;
    end
  end
  assign axi_rsp_o = '{awready: !aw_q && !bv_q, wready: !w_q && !bv_q, bvalid: bv_q,
                       bresp: br_q, arready: !rv_q, rvalid: rv_q, rdata: rd_q, rresp: rr_q};
  assign irq_o = |(stat_q & mask_q);

  // Checks
  AST_INH_FLOAT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_q == M_SLEEP && !wake_q) |-> !regulator_inhibit_out_oe_o)
    else $error("inhibit driven in quiet sleep");
  AST_INH_DRIVE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_q != M_SLEEP || wake_q) |-> regulator_inhibit_out_oe_o)
    else $error("inhibit not driven while awake");
  AST_NO_SLEEP_FLAG: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_q == M_SLEEP && $past(state_q) != M_SLEEP) |-> !$past(wake_q))
    else $error("sleep entered with wake flag set");
  AST_FAULT_STATUS_OUT_N_FLAG: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    low_power(state_q) |-> fault_status_out_n_o == !wake_q)
    else $error("fault status does not show wake flag");
  AST_RXD_MIRROR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    low_power(state_q) |-> rxd_o == fault_status_out_n_o)
    else $error("receive data does not mirror wake flag");
  AST_WAKE_SET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (low_power(state_q) && (bus_wake || loc_wake)) |=> wake_q)
    else $error("wake event lost in low power mode");
  AST_WAKE_IGNORE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (!low_power(state_q) && !pon_rise && !wake_q) |=> !wake_q)
    else $error("wake flag set in active mode");
  AST_UV_CLEAR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (uv_rise && !wake_set) |=> !wake_q)
    else $error("undervoltage did not clear wake flag");
  AST_BUS_PHASE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    bus_wake |-> (bw_q == BW_DOM2 && ph_q >= 10'(PHASE_CYC - 1) && win_q < 17'(WINDOW_CYC - 1)))
    else $error("bus wake without full pattern");
  AST_BIAS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (filt_q[SY_WAKE] != bias_q && fc_q >= 16'(WAKE_FILT_CYC - 1))
    |=> wake_bias_high_o == $past(filt_q[SY_WAKE]))
    else $error("bias did not follow wake pin");
endmodule : can_wake_flag
`default_nettype wire

// file: host_mode_model.sv
// Host model that selects transceiver modes over the two mode pins
`timescale 1ns/1ns
`default_nettype none
module host_mode_model #(
  parameter int SETTLE_CYC = 1250
) (
  input wire logic mclk_i,
  output logic standby_select_n_o,
  output logic enable_o
);
  // Power up in Standby, the same mode the block resets into
  initial begin
    standby_select_n_o = 1'b0;
    enable_o = 1'b0;
  end
  // settle wait, flags are not valid right after a mode change
  task automatic set_mode(input logic standby_select_n, input logic en);
    @(posedge mclk_i);
    standby_select_n_o <= standby_select_n;
    enable_o <= en;
    repeat (SETTLE_CYC) @(posedge mclk_i);
  endtask : set_mode
endmodule : host_mode_model
`default_nettype wire

// file: can_wake_flag_bench.sv
// Self-checking bench of the CAN wake flag block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module can_wake_flag_bench;
  import can_wake_pkg::*;
  logic mclk_i, nrst_i, bus_dom, wake_pin, pon, uv, oth_n;
  logic standby_select_n, en, fault_n, rxd, txd_en, regulator_inhibit_out, inh_oe, bias, irq;
  axil_req_t req;
  axil_rsp_t rsp;
  int err_count, check_count, md, fl, bs, ih;
  logic [31:0] rd, rnd;
  logic [1:0] rr;
  host_mode_model host (.mclk_i(mclk_i), .standby_select_n_o(standby_select_n), .enable_o(en));
  // Short window and filters keep the run brief
  can_wake_flag #(.WINDOW_CYC(2500), .WAKE_FILT_CYC(8), .GTS_HOLD_CYC(16)) dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .bus_dominant_i(bus_dom), .wake_pin_i(wake_pin), .standby_select_n_i(standby_select_n),
    .enable_i(en), .power_on_flag_i(pon), .supply_undervoltage_flag_i(uv),
    .other_flag_n_i(oth_n), .fault_status_out_n_o(fault_n), .rxd_o(rxd),
    .txd_enable_o(txd_en), .regulator_inhibit_out_o(regulator_inhibit_out),
    .regulator_inhibit_out_oe_o(inh_oe), .wake_bias_high_o(bias), .irq_o(irq));
  // Free-running clock, 8 ns
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Handshakes are judged from values settled before the sampling edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n;
    @(posedge mclk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b) begin
      @(negedge mclk_i);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = req.bready & rsp.bvalid;
      r = rsp.bresp;
      @(posedge mclk_i);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      n++;
      if (n > 100) begin
        err_count++;
        report_and_stop();
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    int n;
    @(posedge mclk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    rv = 1'b0;
    n = 0;
    while (!rv) begin
      @(negedge mclk_i);
      ar = req.arvalid & rsp.arready;
      rv = req.rready & rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge mclk_i);
      if (ar) req.arvalid <= 1'b0;
      if (rv) req.rready <= 1'b0;
      n++;
      if (n > 100) begin
        err_count++;
        report_and_stop();
      end
    end
  endtask : axi_rd
  // Compare the status word with the model state
  task automatic chk_st();
    axi_rd(32'h0, rd, rr);
    `CHK("status", ({24'h0, 1'(ih), 1'(bs), 1'(fl), 5'(md)}), rd)
  endtask : chk_st
  // Pin view of the flag in the low-power modes
  task automatic chk_pins();
    `CHK("fault_n", ~1'(fl), fault_n)
    `CHK("rxd", ~1'(fl), rxd)
    `CHK("inh_oe", 1'(ih), inh_oe)
    `CHK("inh", 1'b1, regulator_inhibit_out)
  endtask : chk_pins
  task automatic bus_pat(input int d1, input int r1, input int d2);
    bus_dom <= 1'b1;
    repeat (d1) @(posedge mclk_i);
    bus_dom <= 1'b0;
    repeat (r1) @(posedge mclk_i);
    bus_dom <= 1'b1;
    repeat (d2) @(posedge mclk_i);
    bus_dom <= 1'b0;
    repeat (30) @(posedge mclk_i);
  endtask : bus_pat
  task automatic pin_wake(input logic v);
    wake_pin <= v;
    repeat (60) @(posedge mclk_i);
  endtask : pin_wake
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    bus_dom = 1'b0;
    wake_pin = 1'b1;
    pon = 1'b0;
    uv = 1'b0;
    oth_n = 1'b1;
    req = '0;
    err_count = 0;
    check_count = 0;
    rnd = $urandom(32'h55a4);
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    md = 8;
    fl = 1;
    bs = 1;
    ih = 1;
    chk_st();
    chk_pins();
    axi_rd(32'h4, rd, rr);
    `CHK("ctrl", 32'h3, rd)
    axi_wr(32'h8, 32'hf, rr);
    $display("test reset done");
    oth_n <= 1'($urandom);
    host.set_mode(1'b1, 1'b1);
    md = 1;
    fl = 0;
    chk_st();
    `CHK("txd_en", 1'b1, txd_en)
    `CHK("fault_n", oth_n, fault_n)
    pin_wake(1'b0);
    pin_wake(1'b1);
    axi_rd(32'h0, rd, rr);
    `CHK("flag_ign", 1'b0, rd[5])
    $display("test normal done");
    host.set_mode(1'b0, 1'b0);
    md = 8;
    chk_pins();
    rnd = $urandom & 32'hf;
    axi_wr(32'hc, rnd, rr);
    axi_rd(32'hc, rd, rr);
    `CHK("mask", rnd, rd)
    axi_wr(32'hc, 32'h2, rr);
    // Drop events left over from the Normal mode test so the irq check below can trip
    axi_wr(32'h8, 32'hf, rr);
    `CHK("irq_idle", 1'b0, irq)
    pin_wake(1'b0);
    fl = 1;
    bs = 0;
    chk_st();
    chk_pins();
    `CHK("irq", 1'b1, irq)
    axi_wr(32'h8, 32'h2, rr);
    `CHK("irq_clr", 1'b0, irq)
    pin_wake(1'b1);
    bs = 1;
    `CHK("bias", 1'b1, bias)
    $display("test local wake done");
    host.set_mode(1'b0, 1'b1);
    md = 4;
    chk_st();
    chk_pins();
    `CHK("txd_gts", 1'b0, txd_en)
    host.set_mode(1'b1, 1'b1);
    host.set_mode(1'b0, 1'b1);
    md = 16;
    fl = 0;
    ih = 0;
    chk_st();
    chk_pins();
    axi_rd(32'h8, rd, rr);
    `CHK("sleep_irq", 1'b1, rd[2])
    $display("test sleep done");
    bus_pat(640, 640, 640);
    fl = 1;
    ih = 1;
    chk_st();
    chk_pins();
    host.set_mode(1'b1, 1'b0);
    md = 2;
    chk_st();
    `CHK("rxd_rec", 1'b1, rxd)
    $display("test bus wake done");
    host.set_mode(1'b1, 1'b1);
    host.set_mode(1'b0, 1'b0);
    md = 8;
    fl = 0;
    bus_pat(640, 2000, 640);
    chk_st();
    bus_pat(400, 640, 640);
    chk_st();
    // Local wake disabled: bias still follows the pin, flag stays clear
    axi_wr(32'h4, 32'h0, rr);
    pin_wake(1'b0);
    bs = 0;
    chk_st();
    pin_wake(1'b1);
    bs = 1;
    axi_wr(32'h4, 32'h3, rr);
    $display("test window done");
    pon <= 1'b1;
    repeat (20) @(posedge mclk_i);
    fl = 1;
    chk_pins();
    uv <= 1'b1;
    repeat (20) @(posedge mclk_i);
    fl = 0;
    chk_pins();
    pon <= 1'b0;
    uv <= 1'b0;
    axi_rd(32'h10, rd, rr);
    `CHK("unmapped_rd", RESP_SLVERR, rr)
    axi_wr(32'h20, 32'h1, rr);
    `CHK("unmapped_wr", RESP_SLVERR, rr)
    $display("test flags done");
    report_and_stop();
  end
endmodule : can_wake_flag_bench
`default_nettype wire
